// *** hdl/lmbm_pkg.sv ***
// constants for the local memory bus multiplexer
package lmbm_pkg;
    // ****************************************
    // register map (apb byte addresses)
    // ****************************************
    localparam logic [11:0] ctrl_off   = 12'h000;
    localparam logic [11:0] addr_off   = 12'h004;
    localparam logic [11:0] data_off   = 12'h008;
    localparam logic [11:0] status_off = 12'h00c;
    localparam logic [11:0] stat_off   = 12'h010;
    // adapter control bits
    localparam int boot_bit  = 0;
    localparam int halt_bit  = 1;
    localparam int reset_bit = 2;
    localparam int go_bit    = 3;
    // ****************************************
    // timing
    // ****************************************
    localparam int clk_mhz      = 125;
    localparam int bus4_khz     = 4000;
    localparam int bus6_khz     = 6000;
    // quarter length in clk cycles, rounded down
    localparam int q4_cyc = (clk_mhz * 1000) / (bus4_khz * 4);
    localparam int q6_cyc = (clk_mhz * 1000) / (bus6_khz * 4);
    localparam logic [7:0] q4_cnt = 8'(q4_cyc - 1);
    localparam logic [7:0] q6_cnt = 8'(q6_cyc - 1);
    localparam logic [1:0] q_first  = 2'h0;
    localparam logic [1:0] q_second = 2'h1;
    localparam logic [1:0] q_last   = 2'h3;
    // memory chapters that follow the boot pin
    localparam logic [4:0] chap_lo = 5'h00;
    localparam logic [4:0] chap_hi = 5'h1f;
    typedef enum logic [1:0] {lmbm_idle, lmbm_run} lmbm_state_e;
endpackage

// *** hdl/lmbm_qgen.sv ***
// quarter-cycle enable divider for the local bus
`timescale 1ns/1ps
module lmbm_qgen (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // control
    input  wire logic       run,
    input  wire logic       fast,
    // quarter tick
    output logic            q_tick
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] lim;
    logic       tick_d;

    // ****************************************
    // divider
    // ****************************************
    always_comb begin
        lim    = fast ? lmbm_pkg::q6_cnt : lmbm_pkg::q4_cnt;
        tick_d = 1'b0;
        cnt_d  = cnt_q;
        if (!run) begin
            // preloaded so the first quarter is not one clock longer than the others
            cnt_d = 8'h01;
        end else if (cnt_q >= lim) begin
            cnt_d  = 8'h00;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q  <= 8'h00;
            q_tick <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            q_tick <= tick_d;
        end
    end
endmodule

// *** hdl/lmbm_top.sv ***
// local memory bus sequencer with apb control
// Functional notes
// - reset or the adapter reset bit loads the boot pin into the boot bit.
// - chapters 0 and 31 are ram when the boot bit is high, rom when low.
// - with ram boot no bus cycle starts until the halt bit is cleared.
// - the divide select and speed choose the local bus rate.
// - high byte bus carries ext bit four and a0-a6, status, then d0-d7.
// - low byte bus carries a7-a14, ext bit four and a0-a6, then d8-d15.
// - line zero of each byte bus is the most significant bit.
// - the latch strobe pulses at cycle start and falls with address valid.
// - ext line zero carries ext bit zero, then address bit 12.
// - ext line two carries ext bit two, then address bit 14.
// - high parity line carries ext bits one, zero, then high parity.
// - low parity line carries ext bits three, two, then low parity.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module lmbm_top (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // straps
    input  wire logic        boot_memory_select_pin,
    input  wire logic        clock_divide_select,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // local memory pins
    output logic [7:0]       high_byte_bus,
    output logic [7:0]       low_byte_bus,
    output logic             address_latch_strobe,
    output logic             ext_addr_line_zero,
    output logic             ext_addr_line_two,
    output logic             high_ext_parity_line,
    output logic             low_ext_parity_line,
    output logic             chapter_is_ram
);
    // ****************************************
    // state
    // ****************************************
    lmbm_pkg::lmbm_state_e st_q, st_d;
    logic [3:0]  ctrl_q, ctrl_d;
    logic [19:0] addr_q, addr_d;
    logic [15:0] data_q, data_d;
    logic [7:0]  status_q, status_d;
    logic [1:0]  qtr_q, qtr_d;
    logic [15:0] done_q, done_d;
    logic        boot_load_q, boot_load_d;
    logic        q_tick;
    logic        run;
    logic [31:0] rd_d;
    logic        err_d;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  hb_d, lb_d;
    logic        al_d, x0_d, x2_d, ph_d, pl_d;

    // reverses bit order so bit 0 lands on line 7
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            rev8[i] = v[7 - i];
        end
    endfunction

    assign run   = (st_q == lmbm_pkg::lmbm_run);
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    lmbm_qgen u_qgen (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (run),
        .fast    (!clock_divide_select && ctrl_q[lmbm_pkg::go_bit]),
        .q_tick  (q_tick)
    );

    // ****************************************
    // control and apb
    // ****************************************
    always_comb begin
        ctrl_d      = ctrl_q;
        addr_d      = addr_q;
        data_d      = data_q;
        status_d    = status_q;
        boot_load_d = 1'b0;
        rd_d        = 32'h0000_0000;
        err_d       = 1'b0;
        if (wr_en) begin
            case (paddr)
                lmbm_pkg::ctrl_off:   ctrl_d   = pwdata[3:0];
                lmbm_pkg::addr_off:   addr_d   = pwdata[19:0];
                lmbm_pkg::data_off:   data_d   = pwdata[15:0];
                lmbm_pkg::status_off: status_d = pwdata[7:0];
                lmbm_pkg::stat_off:   err_d    = 1'b1;
                default:              err_d    = 1'b1;
            endcase
            // boot bit is read-only, software writes keep its current value
            ctrl_d[lmbm_pkg::boot_bit] = ctrl_q[lmbm_pkg::boot_bit];
        end
        if (rd_en) begin
            case (paddr)
                lmbm_pkg::ctrl_off:   rd_d = {28'h0, ctrl_q};
                lmbm_pkg::addr_off:   rd_d = {12'h0, addr_q};
                lmbm_pkg::data_off:   rd_d = {16'h0, data_q};
                lmbm_pkg::status_off: rd_d = {24'h0, status_q};
                lmbm_pkg::stat_off:   rd_d = {done_q, 14'h0, qtr_q};
                default:              rd_d = 32'h0000_0000;
            endcase
        end
        if (ctrl_q[lmbm_pkg::reset_bit]) begin
            boot_load_d                 = 1'b1;
            ctrl_d[lmbm_pkg::reset_bit] = 1'b0;
        end
        if (boot_load_q) begin
            ctrl_d[lmbm_pkg::boot_bit] = boot_memory_select_pin;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q      <= 4'h2;
            addr_q      <= 20'h00000;
            data_q      <= 16'h0000;
            status_q    <= 8'h00;
            boot_load_q <= 1'b1;
            prdata      <= 32'h0000_0000;
            pslverr     <= 1'b0;
            pready      <= 1'b0;
        end else begin
            ctrl_q      <= ctrl_d;
            addr_q      <= addr_d;
            data_q      <= data_d;
            status_q    <= status_d;
            boot_load_q <= boot_load_d;
            if (rd_en) begin
                prdata <= rd_d;
            end
            pslverr <= (psel && !penable) &&
                       !(paddr == lmbm_pkg::ctrl_off ||
                         paddr == lmbm_pkg::addr_off ||
                         paddr == lmbm_pkg::data_off ||
                         paddr == lmbm_pkg::status_off ||
                         (paddr == lmbm_pkg::stat_off && !pwrite));
            pready  <= psel && !penable;
        end
    end

    // ****************************************
    // cycle sequencer
    // ****************************************
    always_comb begin
        st_d   = st_q;
        qtr_d  = qtr_q;
        done_d = done_q;
        case (st_q)
            lmbm_pkg::lmbm_idle: begin
                if (!(ctrl_q[lmbm_pkg::boot_bit] &&
                      ctrl_q[lmbm_pkg::halt_bit]) && !boot_load_q) begin
                    st_d  = lmbm_pkg::lmbm_run;
                    qtr_d = lmbm_pkg::q_first;
                end
            end
            lmbm_pkg::lmbm_run: begin
                if (q_tick) begin
                    qtr_d = qtr_q + 2'h1;
                    if (qtr_q == lmbm_pkg::q_last) begin
                        done_d = done_q + 16'h0001;
                        if (ctrl_q[lmbm_pkg::boot_bit] &&
                            ctrl_q[lmbm_pkg::halt_bit]) begin
                            st_d = lmbm_pkg::lmbm_idle;
                        end
                    end
                end
            end
            default: st_d = lmbm_pkg::lmbm_idle;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q   <= lmbm_pkg::lmbm_idle;
            qtr_q  <= 2'h0;
            done_q <= 16'h0000;
        end else begin
            st_q   <= st_d;
            qtr_q  <= qtr_d;
            done_q <= done_d;
        end
    end

    // ****************************************
    // pin multiplexer
    // ****************************************
    always_comb begin
        hb_d = 8'h00;
        lb_d = 8'h00;
        x0_d = 1'b0;
        x2_d = 1'b0;
        ph_d = 1'b0;
        pl_d = 1'b0;
        al_d = (qtr_d == lmbm_pkg::q_first) &&
               (st_d == lmbm_pkg::lmbm_run);
        if (st_d == lmbm_pkg::lmbm_run) begin
            x0_d = (qtr_d == lmbm_pkg::q_first) ? addr_q[16] : addr_q[12];
            x2_d = (qtr_d == lmbm_pkg::q_first) ? addr_q[18] : addr_q[14];
            case (qtr_d)
                // address quarter, msb on line zero
                2'h0: begin
                    hb_d = rev8({addr_q[6:0], addr_q[15]});
                    lb_d = rev8(addr_q[14:7]);
                    ph_d = addr_q[17];
                    pl_d = addr_q[19];
                end
                2'h1: begin
                    hb_d = rev8(status_q);
                    lb_d = rev8({addr_q[6:0], addr_q[15]});
                    ph_d = addr_q[16];
                    pl_d = addr_q[18];
                end
                default: begin
                    hb_d = rev8(data_q[7:0]);
                    lb_d = rev8(data_q[15:8]);
                    ph_d = ^data_q[7:0];
                    pl_d = ^data_q[15:8];
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            high_byte_bus        <= 8'h00;
            low_byte_bus         <= 8'h00;
            address_latch_strobe <= 1'b0;
            ext_addr_line_zero   <= 1'b0;
            ext_addr_line_two    <= 1'b0;
            high_ext_parity_line <= 1'b0;
            low_ext_parity_line  <= 1'b0;
            chapter_is_ram       <= 1'b0;
        end else begin
            high_byte_bus        <= hb_d;
            low_byte_bus         <= lb_d;
            address_latch_strobe <= al_d;
            ext_addr_line_zero   <= x0_d;
            ext_addr_line_two    <= x2_d;
            high_ext_parity_line <= ph_d;
            low_ext_parity_line  <= pl_d;
            chapter_is_ram       <= ctrl_q[lmbm_pkg::boot_bit] &&
                                    (addr_q[19:15] == lmbm_pkg::chap_lo ||
                                     addr_q[19:15] == lmbm_pkg::chap_hi);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // pins follow the quarter count at once but use last cycle's registers
    sequence s_q_advance;
        run && q_tick;
    endsequence
    sequence s_data_half;
        run && qtr_q[1];
    endsequence
    sequence s_addr_tail;
        run && qtr_q != lmbm_pkg::q_first;
    endsequence
    a_halt_blocks: assert property (
        @(posedge clk) disable iff (sys_rst)
        (st_q == lmbm_pkg::lmbm_idle && ctrl_q[lmbm_pkg::boot_bit] &&
         ctrl_q[lmbm_pkg::halt_bit]) |=> !address_latch_strobe)
        else $error("cycle started while halted");
    a_parity_high: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_data_half |-> high_ext_parity_line == ^$past(data_q[7:0]))
        else $error("high parity wrong");
    a_parity_low: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_data_half |-> low_ext_parity_line == ^$past(data_q[15:8]))
        else $error("low parity wrong");
    a_ext_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_addr_tail |-> ext_addr_line_zero == $past(addr_q[12]))
        else $error("ext line zero wrong");
    a_ext_two: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_addr_tail |-> ext_addr_line_two == $past(addr_q[14]))
        else $error("ext line two wrong");
    a_strobe_quarter: assert property (
        @(posedge clk) disable iff (sys_rst)
        address_latch_strobe |-> qtr_q == lmbm_pkg::q_first)
        else $error("strobe outside first quarter");
    a_quarter_step: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_q_advance |=> qtr_q == $past(qtr_q) + 2'h1)
        else $error("quarter skipped or repeated");
    a_rom_chapter: assert property (
        @(posedge clk) disable iff (sys_rst)
        !ctrl_q[lmbm_pkg::boot_bit] |=> !chapter_is_ram)
        else $error("chapter shown as ram with rom boot");
endmodule

// *** tb/lmbm_latch_model.sv ***
// passive address latch model on the local memory pins
`timescale 1ns/1ps
module lmbm_latch_model (
    // clock
    input  wire logic       clk,
    // memory pins
    input  wire logic [7:0] high_byte_bus,
    input  wire logic [7:0] low_byte_bus,
    input  wire logic       address_latch_strobe,
    input  wire logic       ext_addr_line_zero,
    input  wire logic       ext_addr_line_two,
    input  wire logic       high_ext_parity_line,
    input  wire logic       low_ext_parity_line,
    // latched 20-bit address
    output logic [19:0]     latched_q
);
    // capture on falling strobe
    // sampled per clock while open: avoids a hold race at the fall
    always_ff @(posedge clk) begin
        if (address_latch_strobe) begin
            latched_q <= {ext_addr_line_zero, high_ext_parity_line,
                          ext_addr_line_two, low_ext_parity_line,
                          high_byte_bus, low_byte_bus};
        end
    end
endmodule

// *** tb/lmbm_top_bench.sv ***
// self-checking bench for the local memory bus sequencer
`timescale 1ns/1ps
module lmbm_top_bench;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        boot = 1'b1;
    logic        cds = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, stb, ram;
    logic [7:0]  hbus, lbus, hb[4], lb[4];
    logic        x0w, x2w, phw, plw;
    logic        x0[4], x2[4], ph[4], pl[4];
    logic [19:0] latched_q;
    int          fails = 0;
    int          cmp_count = 0;
    int          qlen, slow;
    always #4 clk = ~clk;
    lmbm_top lmbm_top_inst (.clk(clk), .sys_rst(sys_rst),
        .boot_memory_select_pin(boot), .clock_divide_select(cds),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .high_byte_bus(hbus), .low_byte_bus(lbus),
        .address_latch_strobe(stb), .ext_addr_line_zero(x0w),
        .ext_addr_line_two(x2w), .high_ext_parity_line(phw),
        .low_ext_parity_line(plw), .chapter_is_ram(ram));
    lmbm_latch_model lmbm_latch_model_inst (.clk(clk),
        .high_byte_bus(hbus), .low_byte_bus(lbus),
        .address_latch_strobe(stb), .ext_addr_line_zero(x0w),
        .ext_addr_line_two(x2w), .high_ext_parity_line(phw),
        .low_ext_parity_line(plw), .latched_q(latched_q));
    // ****************************************
    // tasks
    // ****************************************
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev8[i] = v[7-i];
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) fails++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_rise();
        int n;
        n = 0;
        while (stb !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        while (stb !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) fails++;
    endtask
    task automatic measure();
        int p;
        wait_rise();
        qlen = 0;
        while (stb === 1'b1 && qlen < 300) begin
            @(negedge clk);
            qlen++;
        end
        p = qlen;
        while (stb === 1'b0 && p < 1200) begin
            @(negedge clk);
            p++;
        end
        chk(p, 4 * qlen);
    endtask
    task automatic cyc(input logic [19:0] a, input logic [15:0] d,
                       input logic [7:0] s);
        int k;
        apb(1'b1, lmbm_pkg::addr_off, {12'h000, a});
        apb(1'b1, lmbm_pkg::data_off, {16'h0000, d});
        apb(1'b1, lmbm_pkg::status_off, {24'h000000, s});
        // one whole cycle flushed so new values stand from its start
        wait_rise();
        @(negedge clk);
        wait_rise();
        for (int i = 0; i < 4 * qlen; i++) begin
            k = i / qlen;
            if (i % qlen == qlen / 2) begin
                hb[k] = hbus;
                lb[k] = lbus;
                x0[k] = x0w;
                x2[k] = x2w;
                ph[k] = phw;
                pl[k] = plw;
            end
            if (i == qlen - 1) chk(stb, 1'b1);
            if (i == qlen) chk(stb, 1'b0);
            @(negedge clk);
        end
        chk(hb[0], rev8({a[6:0], a[15]}));
        chk(lb[0], rev8(a[14:7]));
        chk(hb[1], rev8(s));
        chk(lb[1], rev8({a[6:0], a[15]}));
        for (int j = 2; j < 4; j++) begin
            chk(hb[j], rev8(d[7:0]));
            chk(lb[j], rev8(d[15:8]));
            chk(ph[j], ^d[7:0]);
            chk(pl[j], ^d[15:8]);
        end
        chk({x0[0], x0[1], x0[2], x0[3]}, {a[16], {3{a[12]}}});
        chk({x2[0], x2[1], x2[2], x2[3]}, {a[18], {3{a[14]}}});
        chk({ph[0], ph[1]}, {a[17], a[16]});
        chk({pl[0], pl[1]}, {a[19], a[18]});
        chk(latched_q, {a[16], a[17], a[18], a[19], rev8({a[6:0], a[15]}),
                        rev8(a[14:7])});
    endtask
    task automatic ram_at(input logic [19:0] a, input logic exp);
        apb(1'b1, lmbm_pkg::addr_off, {12'h000, a});
        repeat (4) @(posedge clk);
        chk(ram, exp);
    endtask
    task automatic final_report();
        $display("compares=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        int n;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, lmbm_pkg::ctrl_off, 32'h0);
        chk(rd[1:0], 2'h3);
        n = 0;
        repeat (200) @(negedge clk) if (stb !== 1'b0) n++;
        chk(n, 0);
        ram_at(20'h00000, 1'b1);
        ram_at(20'hf8123, 1'b1);
        ram_at(20'h08000, 1'b0);
        apb(1'b1, lmbm_pkg::ctrl_off, 32'h0);
        measure();
        slow = qlen;
        chk(slow, lmbm_pkg::q4_cyc);
        cyc(20'ha5a5a, 16'h1234, 8'h81);
        cyc(20'h5a5a5, 16'hfe01, 8'h3c);
        @(posedge clk);
        cds <= 1'b0;
        apb(1'b1, lmbm_pkg::ctrl_off, 32'h8);
        measure();
        chk(qlen < slow, 1'b1);
        chk(qlen, lmbm_pkg::q6_cyc);
        cyc(20'h0f0f0, 16'h00ff, 8'h01);
        @(posedge clk);
        cds <= 1'b1;
        measure();
        chk(qlen, slow);
        @(posedge clk);
        boot <= 1'b0;
        apb(1'b1, lmbm_pkg::ctrl_off, 32'h6);
        repeat (4) @(posedge clk);
        apb(1'b0, lmbm_pkg::ctrl_off, 32'h0);
        chk(rd[0], 1'b0);
        ram_at(20'h00000, 1'b0);
        measure();
        chk(qlen, slow);
        apb(1'b1, lmbm_pkg::stat_off, 32'h1);
        chk(er, 1'b1);
        apb(1'b0, 12'h020, 32'h0);
        chk(er, 1'b1);
        final_report();
    end
    // hang guard: tests need well under 20000 cycles
    initial begin
        #400000;
        fails++;
        final_report();
    end
endmodule
